// *** hw/ccx_top.sv ***
// Checksum and CRC accelerator with AXI4-Lite register slave
//
// Behaviour
// - Entry takes one cycle per input byte
// - Width field selects 8/16/24/32-bit input
// - Flip mirrors input bits within selected width
// - Result and seed never bit-flipped
// - Checksum adds previous carry unless discarded
// - Seed bit loads data port into seed
// - Function 000 disables the engine
// - 001 is 8-bit, 010 is 32-bit checksum
// - 011 is CRC-16 polynomial 8005
// - 100 is CRC-16 polynomial 1021
// - 101 is CRC-32 polynomial; 110 reserved
// - 111 clears state, restores default seed
// - Busy flag reads one while computing
// - Low byte write starts the calculation
// - Data port bytes read back the result
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps

module ccx_top
  import ccx_pkg::*;
#(
  parameter int ADDR_W = 18
) (
  input  wire logic              aclk,    // System clock, 20 MHz
  input  wire logic              aresetn, // Synchronous reset, active low
  input  wire logic [ADDR_W-1:0] awaddr,  // Write address
  input  wire logic [2:0]        awprot,  // Write protection, unused
  input  wire logic              awvalid, // Write address valid
  output logic                   awready, // Write address ready
  input  wire logic [31:0]       wdata,   // Write data
  input  wire logic [3:0]        wstrb,   // Write byte strobes
  input  wire logic              wvalid,  // Write data valid
  output logic                   wready,  // Write data ready
  output logic [1:0]             bresp,   // Write response
  output logic                   bvalid,  // Write response valid
  input  wire logic              bready,  // Write response ready
  input  wire logic [ADDR_W-1:0] araddr,  // Read address
  input  wire logic [2:0]        arprot,  // Read protection, unused
  input  wire logic              arvalid, // Read address valid
  output logic                   arready, // Read address ready
  output logic [31:0]            rdata,   // Read data
  output logic [1:0]             rresp,   // Read response
  output logic                   rvalid,  // Read data valid
  input  wire logic              rready   // Read data ready
);

  typedef struct packed {
    logic              awready;
    logic [ADDR_W-1:0] awaddr;
    logic              wready;
    logic [7:0]        wbyte;
    logic              wlane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic [ADDR_W-1:0] araddr;
    logic              rvalid;
    logic [1:0]        rresp;
    logic [31:0]       rdata;
    logic [1:0]        width;
    logic              reverse;
    logic              discard;
    logic              seed;
    logic [2:0]        func;
    logic [23:0]       hold;
    logic [31:0]       result;
    logic              carry;
    logic [2:0]        left;
    logic [31:0]       shreg;
  } ccx_state_type;

  ccx_state_type st;
  ccx_state_type next_st;

  // Decode one byte address into a register select
  function automatic ccx_sel_type decode(input logic [ADDR_W-1:0] addr);
    logic [ADDR_W-1:0] idx;
    idx = {2'b00, addr[ADDR_W-1:2]};
    decode = SEL_NONE;
    if (addr[1:0] == 2'b00) begin
      if (idx == ADDR_W'(IDX_CONFIG)) decode = SEL_CONFIG;
      else if (idx == ADDR_W'(IDX_DATA_BYTE0)) decode = SEL_BYTE0;
      else if (idx == ADDR_W'(IDX_DATA_BYTE1)) decode = SEL_BYTE1;
      else if (idx == ADDR_W'(IDX_DATA_BYTE2)) decode = SEL_BYTE2;
      else if (idx == ADDR_W'(IDX_DATA_BYTE3)) decode = SEL_BYTE3;
    end
  endfunction

  // One byte through a 16-bit CRC, MSB first, no reflection
  function automatic logic [15:0] crc16_byte(input logic [15:0] crc, input logic [7:0] d,
                                             input logic [15:0] poly);
    logic [15:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ d[i];
      c = {c[14:0], 1'b0} ^ (fb ? poly : 16'h0000);
    end
    crc16_byte = c;
  endfunction

  // One byte through the 32-bit CRC, MSB first, no reflection
  function automatic logic [31:0] crc32_byte(input logic [31:0] crc, input logic [7:0] d);
    logic [31:0] c;
    logic        fb;
    c = crc;
    for (int i = 7; i >= 0; i--) begin
      fb = c[31] ^ d[i];
      c = {c[30:0], 1'b0} ^ (fb ? POLY_CRC32 : 32'h00000000);
    end
    crc32_byte = c;
  endfunction

  // Bit mirror of a full word
  function automatic logic [31:0] mirror(input logic [31:0] w);
    for (int i = 0; i < 32; i++) begin
      mirror[i] = w[31-i];
    end
  endfunction

  // Default seed of the programmed function
  function automatic logic [31:0] default_seed(input logic [2:0] fn);
    unique case (fn)
      FN_CRC_A, FN_CRC_B: default_seed = SEED_CRC16;
      FN_CRC32:           default_seed = SEED_CRC32;
      default:            default_seed = SEED_CHECKSUM;
    endcase
  endfunction

  // Combinational helpers
  ccx_sel_type wsel;
  ccx_sel_type rsel;
  logic        aw_held;
  logic        w_held;
  logic        ar_held;
  logic        idle;
  logic [31:0] entry;
  logic [31:0] masked;
  logic [31:0] aligned;
  logic [4:0]  pad;
  logic [32:0] sum32;
  logic [8:0]  sum8;
  logic [7:0]  cur_byte;
  logic        carry_in;
  logic        engine_on;

  assign wsel    = decode(st.awaddr);
  assign rsel    = decode(st.araddr);
  assign aw_held = !st.awready && !st.bvalid;
  assign w_held  = !st.wready && !st.bvalid;
  assign ar_held = !st.arready && !st.rvalid;
  assign idle    = (st.left == 3'h0);

  // Engine input word built from held high bytes and the low byte
  assign entry    = {st.hold, st.wbyte};
  assign pad      = 5'((3 - int'(st.width)) * 8);
  assign masked   = (entry << pad) >> pad;
  // Mirror lands the flipped word left-aligned, as the byte feed wants
  assign aligned  = st.reverse ? mirror(masked) : (masked << pad);
  assign carry_in = st.carry && !st.discard;
  assign sum32    = {1'b0, st.result} + {1'b0, aligned >> pad} + 33'(carry_in);
  assign cur_byte = st.shreg[31:24];
  assign sum8     = {1'b0, st.result[7:0]} + {1'b0, cur_byte} + 9'(carry_in);
  // Reserved and off codes never start the engine
  assign engine_on = (st.func != FN_OFF) && (st.func != FN_RSVD);

  // Next-state logic
  always_comb begin
    next_st = st;

    // Per-byte engine step, one input byte each cycle
    if (!idle) begin
      next_st.left  = st.left - 3'h1;
      next_st.shreg = {st.shreg[23:0], 8'h00};
      unique case (st.func)
        FN_CK8: begin
          next_st.result = {24'h000000, sum8[7:0]};
          next_st.carry  = sum8[8];
        end
        FN_CRC_A: next_st.result = {16'h0000, crc16_byte(st.result[15:0], cur_byte,
                                                         POLY_CRC_A)};
        FN_CRC_B: next_st.result = {16'h0000, crc16_byte(st.result[15:0], cur_byte,
                                                         POLY_CRC_B)};
        FN_CRC32: next_st.result = crc32_byte(st.result, cur_byte);
        default: ;
      endcase
    end

    // Address and data channels taken independently
    if (awvalid && st.awready) begin
      next_st.awready = 1'b0;
      next_st.awaddr  = awaddr;
    end
    if (wvalid && st.wready) begin
      next_st.wready = 1'b0;
      next_st.wbyte  = wdata[7:0];
      next_st.wlane  = wstrb[0];
    end

    // Register write once both halves are held and the engine is idle
    if (aw_held && w_held && idle) begin
      next_st.bvalid = 1'b1;
      next_st.bresp  = (wsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (st.wlane) begin
        unique case (wsel)
          SEL_CONFIG: begin
            next_st.width   = st.wbyte[CFG_WIDTH_POS+:2];
            next_st.reverse = st.wbyte[CFG_REVERSE_POS];
            next_st.discard = st.wbyte[CFG_DISCARD_POS];
            next_st.seed    = st.wbyte[CFG_SEED_POS];
            // Clear keeps the programmed function so the seed matches it
            if (st.wbyte[2:0] == FN_CLEAR) begin
              next_st.result = default_seed(st.func);
              next_st.carry  = 1'b0;
              next_st.hold   = 24'h000000;
            end else begin
              next_st.func = st.wbyte[2:0];
            end
          end
          SEL_BYTE1: next_st.hold[7:0]   = st.wbyte;
          SEL_BYTE2: next_st.hold[15:8]  = st.wbyte;
          SEL_BYTE3: next_st.hold[23:16] = st.wbyte;
          SEL_BYTE0: begin
            if (st.seed) begin
              next_st.result = entry;
              next_st.carry  = 1'b0;
            end else if (engine_on) begin
              next_st.left  = 3'({1'b0, st.width} + 3'h1);
              next_st.shreg = aligned;
              if (st.func == FN_CK32) begin
                next_st.result = sum32[31:0];
                next_st.carry  = sum32[32];
              end
            end
          end
          default: ;
        endcase
      end
    end

    // Write response retires, both write channels reopen
    if (st.bvalid && bready) begin
      next_st.bvalid  = 1'b0;
      next_st.awready = 1'b1;
      next_st.wready  = 1'b1;
    end

    // Read path
    if (arvalid && st.arready) begin
      next_st.arready = 1'b0;
      next_st.araddr  = araddr;
    end
    // Configuration reads stall nothing, result reads wait for idle
    if (ar_held && (idle || rsel == SEL_CONFIG)) begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = (rsel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rsel)
        SEL_CONFIG: next_st.rdata = {24'h000000, st.width, st.reverse, st.discard, st.seed,
                                     2'b00, !idle};
        SEL_BYTE0:  next_st.rdata = {24'h000000, st.result[7:0]};
        SEL_BYTE1:  next_st.rdata = {24'h000000, st.result[15:8]};
        SEL_BYTE2:  next_st.rdata = {24'h000000, st.result[23:16]};
        SEL_BYTE3:  next_st.rdata = {24'h000000, st.result[31:24]};
        default:    next_st.rdata = 32'h00000000;
      endcase
    end
    if (st.rvalid && rready) begin
      next_st.rvalid  = 1'b0;
      next_st.arready = 1'b1;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st         <= '0;
      st.awready <= 1'b1;
      st.wready  <= 1'b1;
      st.arready <= 1'b1;
      st.width   <= CONFIG_RESET[CFG_WIDTH_POS+:2];
      st.func    <= CONFIG_RESET[2:0];
      st.wbyte   <= DATA_RESET;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from the state flops
  assign awready = st.awready;
  assign wready  = st.wready;
  assign bvalid  = st.bvalid;
  assign bresp   = st.bresp;
  assign arready = st.arready;
  assign rvalid  = st.rvalid;
  assign rresp   = st.rresp;
  assign rdata   = st.rdata;

endmodule

// *** pkg/ccx_pkg.sv ***
// Constants, field layout and register select type of the checksum and CRC accelerator
package ccx_pkg;

  // Register indices; byte address on the bus is four times the index
  localparam logic [15:0] IDX_CONFIG     = 16'ha078;
  localparam logic [15:0] IDX_DATA_BYTE0 = 16'ha07c;
  localparam logic [15:0] IDX_DATA_BYTE1 = 16'ha07d;
  localparam logic [15:0] IDX_DATA_BYTE2 = 16'ha07e;
  localparam logic [15:0] IDX_DATA_BYTE3 = 16'ha07f;

  // Configuration register field positions
  localparam int CFG_WIDTH_POS   = 6;
  localparam int CFG_REVERSE_POS = 5;
  localparam int CFG_DISCARD_POS = 4;
  localparam int CFG_SEED_POS    = 3;
  localparam int CFG_BUSY_POS    = 0;

  // Reset values
  localparam logic [7:0]  CONFIG_RESET = 8'h00;
  localparam logic [7:0]  DATA_RESET   = 8'h00;

  // Function select codes
  localparam logic [2:0] FN_OFF   = 3'h0;
  localparam logic [2:0] FN_CK8   = 3'h1;
  localparam logic [2:0] FN_CK32  = 3'h2;
  localparam logic [2:0] FN_CRC_A = 3'h3;
  localparam logic [2:0] FN_CRC_B = 3'h4;
  localparam logic [2:0] FN_CRC32 = 3'h5;
  localparam logic [2:0] FN_RSVD  = 3'h6;
  localparam logic [2:0] FN_CLEAR = 3'h7;

  // Polynomials, implicit top bit left out
  localparam logic [15:0] POLY_CRC_A = 16'h8005;
  localparam logic [15:0] POLY_CRC_B = 16'h1021;
  localparam logic [31:0] POLY_CRC32 = 32'h04c11db7;

  // Default seeds restored by the clear command
  localparam logic [31:0] SEED_CHECKSUM = 32'h00000000;
  localparam logic [31:0] SEED_CRC16    = 32'h0000ffff;
  localparam logic [31:0] SEED_CRC32    = 32'hffffffff;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Register select after address decode
  typedef enum logic [2:0] {
    SEL_CONFIG, SEL_BYTE0, SEL_BYTE1, SEL_BYTE2, SEL_BYTE3, SEL_NONE
  } ccx_sel_type;

endpackage

// *** bench/ccx_checker.sv ***
// Bus-port assertions for the checksum and CRC accelerator
`timescale 1ns/100ps
module ccx_checker
  import ccx_pkg::*;
#(parameter int ADDR_W = 18) (
  input wire logic              aclk,    // Clock
  input wire logic              aresetn, // Reset
  input wire logic [ADDR_W-1:0] awaddr,  // Wr addr
  input wire logic [2:0]        awprot,  // Unused
  input wire logic              awvalid, // Wr addr valid
  input wire logic              awready, // Wr addr ready
  input wire logic [31:0]       wdata,   // Wr data
  input wire logic [3:0]        wstrb,   // Strobes
  input wire logic              wvalid,  // Wr data valid
  input wire logic              wready,  // Wr data ready
  input wire logic [1:0]        bresp,   // Wr resp
  input wire logic              bvalid,  // Wr resp valid
  input wire logic              bready,  // Wr resp ready
  input wire logic [ADDR_W-1:0] araddr,  // Rd addr
  input wire logic [2:0]        arprot,  // Unused
  input wire logic              arvalid, // Rd addr valid
  input wire logic              arready, // Rd addr ready
  input wire logic [31:0]       rdata,   // Rd data
  input wire logic [1:0]        rresp,   // Rd resp
  input wire logic              rvalid,  // Rd data valid
  input wire logic              rready   // Rd data ready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Handshakes that open a write or a read
  sequence s_wr; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd; arvalid && arready; endsequence
  // Answer at the 2nd edge, later only by the busy cycles
  a_wr_answer: assert property (s_wr |=> !bvalid && !awready ##[1:5] bvalid)
    else $error("write answer late");
  a_rd_answer: assert property (s_rd |=> !rvalid && !arready ##[1:5] rvalid)
    else $error("read answer late");
  // Request channels stay shut while an answer waits, so no second request slips in
  a_b_hold: assert property (bvalid |-> !awready && !wready)
    else $error("write path open during response");
  a_r_hold: assert property (rvalid |-> !arready)
    else $error("read path open during response");
  a_rd_byte: assert property (rvalid |-> rdata[31:8] == 24'h0)
    else $error("read upper bits set");
  a_bad_addr: assert property ((s_rd and araddr[1:0] != 2'h0) |->
                               ##[2:6] rvalid && rresp == RESP_SLVERR)
    else $error("misaligned read not refused");
  a_good_addr: assert property ((s_rd and araddr == 18'h281f0) |->
                                ##[2:6] rvalid && rresp == RESP_OKAY)
    else $error("result read refused");
  a_ready_back: assert property (bvalid && bready |=> !bvalid && awready && wready)
    else $error("write path not freed");
endmodule

bind ccx_top ccx_checker #(.ADDR_W(ADDR_W)) u_chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
  .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(arprot),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready)
);

// *** bench/ccx_cpu_model.sv ***
// Bus master standing in for the CPU core
`timescale 1ns/100ps
module ccx_cpu_model #(parameter int ADDR_W = 18) (
  input  wire logic              aclk,    // Clock
  output logic [ADDR_W-1:0]      awaddr,  // Wr addr
  output logic                   awvalid, // Wr addr valid
  input  wire logic              awready, // Wr addr ready
  output logic [31:0]            wdata,   // Wr data
  output logic                   wvalid,  // Wr data valid
  input  wire logic              wready,  // Wr data ready
  input  wire logic [1:0]        bresp,   // Wr resp
  input  wire logic              bvalid,  // Wr resp valid
  output logic                   bready,  // Wr resp ready
  output logic [ADDR_W-1:0]      araddr,  // Rd addr
  output logic                   arvalid, // Rd addr valid
  input  wire logic              arready, // Rd addr ready
  input  wire logic [31:0]       rdata,   // Rd data
  input  wire logic [1:0]        rresp,   // Rd resp
  input  wire logic              rvalid,  // Rd data valid
  output logic                   rready   // Rd data ready
);
  logic slow = 1'b0; // Idle cycle before each request when set
  // Idle bus from time zero
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
  end
  // Released lines are inverted so stale values never look valid
  // Response ready is raised with the request and held until the answer
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [1:0] s);
    if (slow) @(posedge aclk);
    @(posedge aclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) {awvalid, awaddr} <= {1'b0, ~awaddr};
      if (wvalid && wready) {wvalid, wdata} <= {1'b0, ~wdata};
    end while (!(bvalid && bready));
    s = bresp;
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] s);
    if (slow) @(posedge aclk);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) {arvalid, araddr} <= {1'b0, ~araddr};
    end while (!(rvalid && rready));
    d = rdata;
    s = rresp;
    rready <= 1'b0;
  endtask
endmodule

// *** bench/tb.sv ***
// Register-level tests of the checksum and CRC accelerator
`timescale 1ns/100ps
module tb;
  import ccx_pkg::*;
  localparam logic [17:0] A_CFG = 18'h281e0; // Config word
  localparam logic [17:0] A_DAT = 18'h281f0; // Data byte 0, byte k at 4k above
  typedef struct packed {logic [2:0] fn; logic [1:0] wd; logic fl; logic [31:0] d;} ccx_case_type;
  ccx_case_type cases [6] = '{'{FN_CK8, 2'h1, 1'h0, 32'h1234}, '{FN_CK32, 2'h3, 1'h0, 32'h89abcdef},
    '{FN_CRC_A, 2'h1, 1'h0, 32'h1234}, '{FN_CRC_B, 2'h0, 1'h1, 32'h01},
    '{FN_CRC32, 2'h2, 1'h1, 32'habcdef}, '{FN_CRC32, 2'h3, 1'h0, 32'h12345678}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [17:0] awaddr, araddr;
  logic [31:0] wdata, rdata, res;
  logic [1:0] bresp, rresp, rs;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int error_cnt = 0;
  int tests_run = 0;
  always #25 aclk = ~aclk;
  ccx_top u_dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'h1), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));
  ccx_cpu_model u_cpu (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic w(input logic [17:0] a, input logic [7:0] d);
    u_cpu.wr(a, d, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask
  task automatic r(input logic [17:0] a, output logic [31:0] d);
    u_cpu.rd(a, d, rs);
    chk({30'h0, rs}, {30'h0, RESP_OKAY});
  endtask
  // High bytes first; byte 0 last starts the engine
  task automatic put(input logic [31:0] v, input int n);
    for (int k = n - 1; k >= 0; k--) w(A_DAT + 18'(4 * k), v[8*k +: 8]);
  endtask
  task automatic get(output logic [31:0] v);
    logic [31:0] b;
    for (int k = 0; k < 4; k++) begin
      r(A_DAT + 18'(4 * k), b);
      v[8*k +: 8] = b[7:0];
    end
  endtask
  // Result of one entry after a clear; checksum data chosen carry-free
  function automatic logic [31:0] ref_val(ccx_case_type c);
    int n;
    logic [31:0] e, s, p;
    logic fb;
    n = 8 * (int'(c.wd) + 1);
    e = '0;
    for (int i = 0; i < n; i++) e[c.fl ? n - 1 - i : i] = c.d[i];
    s = c.fn == FN_CRC32 ? SEED_CRC32 : (c.fn > FN_CK32 ? SEED_CRC16 : SEED_CHECKSUM);
    p = c.fn == FN_CRC32 ? POLY_CRC32 : {16'h0, c.fn == FN_CRC_A ? POLY_CRC_A : POLY_CRC_B};
    if (c.fn == FN_CK8) begin
      for (int i = 0; i < n; i += 8) s[7:0] = s[7:0] + e[i +: 8];
    end else if (c.fn == FN_CK32) begin
      s = s + e;
    end else begin
      for (int i = n - 1; i >= 0; i--) begin
        fb = s[c.fn == FN_CRC32 ? 31 : 15] ^ e[i];
        s = (s << 1) ^ (fb ? p : 32'h0);
      end
      if (c.fn != FN_CRC32) s[31:16] = 16'h0;
    end
    return s;
  endfunction
  // Hang guard, well beyond the several hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge aclk);
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    r(A_CFG, res);
    chk(res, 32'h0);
    get(res);
    chk(res, 32'h0);
    u_cpu.rd(A_CFG + 18'h2, res, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    u_cpu.wr(18'h00100, 8'h5a, rs);
    chk({30'h0, rs}, {30'h0, RESP_SLVERR});
    // Each checksum and CRC function, width and flip setting
    foreach (cases[i]) begin
      w(A_CFG, {cases[i].wd, cases[i].fl, 2'h0, cases[i].fn});
      w(A_CFG, {cases[i].wd, cases[i].fl, 2'h0, FN_CLEAR});
      put(cases[i].d, int'(cases[i].wd) + 1);
      // Read lands in the fourth busy cycle: only a 32-bit entry still runs
      r(A_CFG, res);
      chk(res, {24'h0, cases[i].wd, cases[i].fl, 4'h0, cases[i].wd == 2'h3});
      get(res);
      chk(res, ref_val(cases[i]));
      r(A_CFG, res);
      chk(res, {24'h0, cases[i].wd, cases[i].fl, 5'h0});
    end
    // Seed ignores flip; carry kept or dropped, with idle gaps between requests
    u_cpu.slow = 1'b1;
    w(A_CFG, {2'h3, 1'h1, 2'h1, FN_CK32});
    put(32'h12345678, 4);
    get(res);
    chk(res, 32'h12345678);
    for (int k = 1; k >= 0; k--) begin
      w(A_CFG, {2'h3, 3'h1, FN_CK32});
      put(32'hffffffff, 4);
      w(A_CFG, {2'h3, 1'h0, k[0], 1'h0, FN_CK32});
      put(32'h1, 4);
      put(32'h0, 4);
      get(res);
      chk(res, {31'h0, ~k[0]});
    end
    // Off and reserved functions leave the result alone
    for (int k = 0; k < 2; k++) begin
      w(A_CFG, {5'h0, k == 0 ? FN_OFF : FN_RSVD});
      put(32'h5a, 1);
      get(res);
      chk(res, 32'h1);
    end
    report_and_stop();
  end
endmodule
